// File: src/amsr_host.sv
// host end: trigger port, receive port and apb register file
//
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module amsr_host (
  input  wire logic        pclk,
  input  wire logic        presetn,
  amsr_link_if.host        link,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             rx_event
);
  import amsr_pkg::*;

  logic [3:0]           sync_in;
  logic                 clk_s;
  logic                 fs_s;
  logic [1:0]           dat_s;
  logic                 clk_d;
  logic [3:0]           ctrl;
  logic [15:0]          period;
  logic [15:0]          tcnt;
  logic                 cs_n;
  logic [WORD_BITS-1:0] shreg;
  logic [4:0]           bits;
  logic                 in_word;
  logic                 len16;
  logic [1:0]           wcnt;
  logic [WORD_BITS-1:0] data;
  logic                 valid;
  logic [15:0]          count;
  logic [WORD_BITS-1:0] txdata;
  logic [1:0]           tx_bit;

  // clock, frame and both data pins all cross from the link
  amsr_bit_sync #(.W(4)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     ({link.port_data, link.frame_sync, link.bit_clock}),
    .dout    (sync_in)
  );
  assign clk_s = sync_in[0];
  assign fs_s = sync_in[1];
  assign dat_s = sync_in[3:2];

  ////////////////////////////////////////////////////////////////////
  // apb decode
  wire wr = psel & penable & pwrite;
  wire setup = psel & ~penable;
  wire hit_ctrl = (paddr == ADDR_CTRL);
  wire hit_period = (paddr == ADDR_PERIOD);
  wire hit_status = (paddr == ADDR_STATUS);
  wire hit_data = (paddr == ADDR_DATA);
  wire hit_count = (paddr == ADDR_COUNT);
  wire hit_tx = (paddr == ADDR_TXDATA);
  wire mapped = hit_ctrl | hit_period | hit_status | hit_data | hit_count | hit_tx;
  wire clr_valid = wr & hit_status & pwdata[STAT_VALID];

  wire trig_en = ctrl[CTRL_TRIG_EN];
  wire rx_en = ctrl[CTRL_RX_EN];
  wire [1:0] dir = ctrl[CTRL_DIR_LO +: 2];

  wire [31:0] rd_status = {29'h0, len16, in_word, valid};
  wire [31:0] rd_mux = hit_ctrl   ? {28'h0, ctrl} :
                       hit_period ? {16'h0, period} :
                       hit_status ? rd_status :
                       hit_data   ? {16'h0, data} :
                       hit_count  ? {16'h0, count} :
                       hit_tx     ? {16'h0, txdata} : 32'h0;

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl <= CTRL_RST;
      period <= PERIOD_RST;
      txdata <= '0;
      prdata <= 32'h0;
    end
    else
    begin
      if (setup)
        prdata <= rd_mux;
      if (wr && hit_ctrl)
        ctrl <= pwdata[3:0];
      if (wr && hit_period)
        period <= pwdata[15:0];
      if (wr && hit_tx)
        txdata <= pwdata[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // trigger port: free-running frame, never waits on received data
  wire tcnt_wrap = (tcnt >= period - 16'(1));
  wire next_cs_n = ~(trig_en && tcnt < 16'(FS_LOW_CYCLES));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tcnt <= '0;
      cs_n <= 1'b1;
    end
    else
    begin
      tcnt <= (!trig_en || tcnt_wrap) ? 16'(0) : tcnt + 16'(1);
      cs_n <= next_cs_n;
    end
  end
  assign link.conversion_start_n = cs_n;

  ////////////////////////////////////////////////////////////////////
  // receive port on channel 0
  wire rise = clk_s & ~clk_d;
  wire fall = ~clk_s & clk_d;
  wire rx_bit = dat_s[0];
  wire frame_start = rise & ~in_word & ~fs_s;
  wire [4:0] word_len = len16 ? 5'(WORD_BITS) : 5'(FIRST_LEN);
  wire [4:0] next_bits = frame_start ? 5'(1) : bits + 5'(1);
  wire [WORD_BITS-1:0] next_shreg = {shreg[WORD_BITS-2:0], rx_bit};
  wire take = rx_en & rise & (in_word | frame_start);
  wire word_done = take & (next_bits == word_len);
  wire keep = word_done & (wcnt == 2'(DISCARD_WORDS));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      clk_d <= 1'b0;
      shreg <= '0;
      bits <= '0;
      in_word <= 1'b0;
      len16 <= 1'b0;
      wcnt <= '0;
      data <= '0;
      valid <= 1'b0;
      count <= '0;
      rx_event <= 1'b0;
    end
    else
    begin
      clk_d <= clk_s;
      rx_event <= keep;
      if (keep)
      begin
        data <= next_shreg;
        count <= count + 16'(1);
      end
      // a new word wins over a software clear
      valid <= keep | (valid & ~clr_valid);
      if (!rx_en)
      begin
        in_word <= 1'b0;
        bits <= '0;
        len16 <= 1'b0;
        wcnt <= '0;
      end
      else if (take)
      begin
        shreg <= frame_start ? {{(WORD_BITS-1){1'b0}}, rx_bit} : next_shreg;
        bits <= next_bits;
        in_word <= ~word_done;
        if (word_done)
        begin
          len16 <= 1'b1;
          if (wcnt != 2'(DISCARD_WORDS))
            wcnt <= wcnt + 2'(1);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // each data pin either listens or shifts txdata msb first
  wire [3:0] tx_idx = 4'(WORD_BITS - 1) - bits[3:0];

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++)
    begin : g_chan
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          tx_bit[ch] <= 1'b0;
        else if (fall | frame_start)
          tx_bit[ch] <= txdata[tx_idx];
      end
      assign link.port_data_oe[ch] = dir[ch];
      assign link.port_data_o[ch] = tx_bit[ch];
    end
  endgenerate
endmodule : amsr_host

// File: src/amsr_pkg.sv
// constants and types shared by the converter link ends
//
// Contract
// - falling start edge holds sample, starts conversion
// - every delivered result is a 16-bit word
// - invert select picks the shifting clock edge
// - bit clock pin: input slave, output master
// - master bit clock toggles only during transfer
// - no bit clock activity while converting
// - frame sync aligned, polarity selectable
// - throughput up to 500 kSPS
// - host start is active-low early trigger sync
// - trigger sync periodic, independent of data
// - receive clock and frame come from converter
// - receive frame active low, late, first bit
// - converter changes data on falling edges; with clock_edge_invert_sel set it changes data on rising edges
// - host samples data on rising bit clock
// - receive port starts at fifteen-bit words
// - after first word switch to sixteen bits
// - host discards the first two words
// - two data pins, each receiver or transmitter; only pin 0 feeds the receive port, pin 1 input is unused
package amsr_pkg;
  localparam int CLK_MHZ = 50;
  localparam int TCONV_NS = 600;
  localparam int CONV_CYCLES = (TCONV_NS * CLK_MHZ + 999) / 1000;
  localparam int SCLK_HALF = 2;
  localparam int WORD_BITS = 16;
  localparam int FIRST_LEN = 15;
  localparam int DISCARD_WORDS = 2;
  localparam int TRIG_PERIOD_NS = 2000;
  localparam int TRIG_CYCLES = TRIG_PERIOD_NS * CLK_MHZ / 1000;
  localparam int FS_LOW_CYCLES = 4;
  localparam int CHANNELS = 2;

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PERIOD = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_DATA = 8'h0C;
  localparam logic [7:0] ADDR_COUNT = 8'h10;
  localparam logic [7:0] ADDR_TXDATA = 8'h14;

  localparam int CTRL_TRIG_EN = 0;
  localparam int CTRL_RX_EN = 1;
  localparam int CTRL_DIR_LO = 2;
  localparam int STAT_VALID = 0;
  localparam int STAT_IN_WORD = 1;
  localparam int STAT_LEN16 = 2;

  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [15:0] PERIOD_RST = 16'(TRIG_CYCLES);

  typedef enum logic [1:0] {CONV_IDLE, CONV_RUN, CONV_SHIFT} amsr_conv_type;
endpackage : amsr_pkg

// File: src/amsr_link_if.sv
// link wires between converter and host serial ports
`timescale 1ns/1ps
interface amsr_link_if;
  logic       conversion_start_n;
  logic       bit_clock_o;
  logic       bit_clock_oe;
  logic       ext_bit_clock;
  logic       bit_clock;
  logic       frame_sync;
  logic       serial_result_out;
  logic [1:0] port_data_o;
  logic [1:0] port_data_oe;
  logic [1:0] port_data;

  // slave-mode clock comes from the bench through ext_bit_clock
  assign bit_clock = bit_clock_oe ? bit_clock_o : ext_bit_clock;
  assign port_data[0] = port_data_oe[0] ? port_data_o[0] : serial_result_out;
  assign port_data[1] = port_data_oe[1] ? port_data_o[1] : 1'b0;

  modport converter (
    input  conversion_start_n,
    input  bit_clock,
    output bit_clock_o,
    output bit_clock_oe,
    output frame_sync,
    output serial_result_out
  );
  modport host (
    output conversion_start_n,
    output port_data_o,
    output port_data_oe,
    input  bit_clock,
    input  frame_sync,
    input  port_data
  );
endinterface : amsr_link_if

// File: src/amsr_bit_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module amsr_bit_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta <= '0;
      dout <= '0;
    end
    else
    begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule : amsr_bit_sync

// File: src/amsr_converter.sv
// converter end: conversion timing and master/slave serial readout
`timescale 1ns/1ps
module amsr_converter (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  amsr_link_if.converter                 link,
  input  wire logic                      master_mode,
  input  wire logic                      clock_edge_invert_sel,
  input  wire logic                      sync_active_high,
  input  wire logic [amsr_pkg::WORD_BITS-1:0] sample_data,
  output logic                           sample_hold,
  output logic                           conv_busy
);
  import amsr_pkg::*;

  logic [1:0]           sync_in;
  logic                 cs_s;
  logic                 clk_s;
  logic                 cs_d;
  logic                 clk_d;
  amsr_conv_type        state;
  logic [5:0]           cnt;
  logic [3:0]           bitn;
  logic                 phase;
  logic [WORD_BITS-1:0] shreg;
  logic                 dout;

  amsr_bit_sync #(.W(2)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     ({link.bit_clock, ~link.conversion_start_n}),
    .dout    (sync_in)
  );
  // start crosses inverted so the synchroniser's reset value reads as idle high,
  // otherwise the first edge after reset looks like a falling start
  assign cs_s = ~sync_in[0];
  assign clk_s = sync_in[1];

  ////////////////////////////////////////////////////////////////////
  wire start = cs_d & ~cs_s;
  // slave mode: shift when the external clock leaves its sampled level
  wire ext_shift = (clk_d ^ clock_edge_invert_sel) & ~(clk_s ^ clock_edge_invert_sel);
  wire half_end = (cnt == 6'(0));
  wire int_shift = half_end & phase;
  wire do_shift = master_mode ? int_shift : ext_shift;
  wire last_bit = (bitn == 4'(WORD_BITS - 1));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cs_d <= 1'b1;
      clk_d <= 1'b0;
      state <= CONV_IDLE;
      cnt <= '0;
      bitn <= '0;
      phase <= 1'b0;
      shreg <= '0;
      dout <= 1'b0;
      sample_hold <= 1'b0;
    end
    else
    begin
      cs_d <= cs_s;
      clk_d <= clk_s;
      case (state)
        CONV_IDLE:
        begin
          if (start)
          begin
            state <= CONV_RUN;
            sample_hold <= 1'b1;
            shreg <= sample_data;
            cnt <= 6'(CONV_CYCLES - 1);
          end
        end
        CONV_RUN:
        begin
          // clock stays idle until the result is ready
          cnt <= cnt - 6'(1);
          if (half_end)
          begin
            state <= CONV_SHIFT;
            sample_hold <= 1'b0;
            dout <= shreg[WORD_BITS-1];
            shreg <= {shreg[WORD_BITS-2:0], 1'b0};
            bitn <= '0;
            phase <= 1'b0;
            cnt <= 6'(SCLK_HALF - 1);
          end
        end
        CONV_SHIFT:
        begin
          cnt <= half_end ? 6'(SCLK_HALF - 1) : cnt - 6'(1);
          if (master_mode && half_end)
            phase <= ~phase;
          if (do_shift)
          begin
            dout <= shreg[WORD_BITS-1];
            shreg <= {shreg[WORD_BITS-2:0], 1'b0};
            bitn <= bitn + 4'(1);
            if (last_bit)
            begin
              state <= CONV_IDLE;
              phase <= 1'b0;
            end
          end
        end
        default:
          state <= CONV_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  wire in_shift = (state == CONV_SHIFT);
  assign conv_busy = (state == CONV_RUN);
  assign link.bit_clock_oe = master_mode;
  assign link.bit_clock_o = (in_shift & phase) ^ clock_edge_invert_sel;
  assign link.serial_result_out = dout;
  // late frame: marks the first bit
  assign link.frame_sync = (in_shift && bitn == 4'(0)) ^ ~sync_active_high;
endmodule : amsr_converter

// File: test/amsr_link_properties.sv
// link checker for the converter and host serial pair
`timescale 1ns/1ps
module amsr_link_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic conversion_start_n,
  input wire logic bit_clock_oe,
  input wire logic bit_clock,
  input wire logic frame_sync,
  input wire logic serial_result_out
);
  logic [15:0] cnt;
  logic [4:0]  rises;

  // cycles since last start fall, saturating so a stopped trigger reads as idle
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      cnt <= '0;
    else if ($fell(conversion_start_n))
      cnt <= 16'h0001;
    else if (cnt != 16'h0000 && cnt != 16'hFFFF)
      cnt <= cnt + 16'h0001;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      rises <= '0;
    else if ($fell(frame_sync))
      rises <= '0;
    else if ($rose(bit_clock))
      rises <= rises + 5'h01;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  //////////////////////////////////////////////////////////////////////////////
  property p_start_width;
    $fell(conversion_start_n) |-> !conversion_start_n[*4] ##1 conversion_start_n;
  endproperty
  a_start_width: assert property (p_start_width)
    else $error("start pulse width wrong");
  property p_period;
    $fell(conversion_start_n) |-> cnt == 16'h0000 || cnt >= 16'h0064;
  endproperty
  a_period: assert property (p_period)
    else $error("start period too short");
  property p_quiet_conv;
    bit_clock_oe && cnt >= 16'h0001 && cnt <= 16'h001E |-> $stable(bit_clock);
  endproperty
  a_quiet_conv: assert property (p_quiet_conv)
    else $error("bit clock moved during conversion");
  property p_idle;
    bit_clock_oe && (cnt == 16'h0000 || cnt >= 16'h0063) |-> $stable(bit_clock);
  endproperty
  a_idle: assert property (p_idle)
    else $error("bit clock moved outside a frame");
  property p_data_edge;
    $changed(serial_result_out) && bit_clock_oe |-> !bit_clock;
  endproperty
  a_data_edge: assert property (p_data_edge)
    else $error("data changed on rising clock");
  property p_frame_lead;
    $fell(frame_sync) && bit_clock_oe |-> !bit_clock ##2 $rose(bit_clock);
  endproperty
  a_frame_lead: assert property (p_frame_lead)
    else $error("frame not on first bit");
  property p_frame_width;
    $fell(frame_sync) && bit_clock_oe |-> !frame_sync[*4] ##1 frame_sync;
  endproperty
  a_frame_width: assert property (p_frame_width)
    else $error("frame width wrong");
  property p_word_bits;
    bit_clock_oe && cnt == 16'h0063 |-> rises == 5'h10;
  endproperty
  a_word_bits: assert property (p_word_bits)
    else $error("word clock count wrong");

  c_master_frame: cover property ($fell(frame_sync) && bit_clock_oe);
  c_slave_frame: cover property ($fell(frame_sync) && !bit_clock_oe);
  c_full_word: cover property (cnt == 16'h0063 && rises == 5'h10);
endmodule : amsr_link_properties

// File: test/adc_master_serial_readout_tb_top.sv
// bench for converter and host facing each other over the link
`timescale 1ns/1ps
module adc_master_serial_readout_tb_top;
  import amsr_pkg::*;
  logic        pclk;
  logic        presetn;
  logic        master_mode;
  logic        clock_edge_invert_sel;
  logic        sync_active_high;
  logic [15:0] sample_data;
  logic        sample_hold;
  logic        conv_busy;
  logic [7:0]  paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rx_event;
  logic [31:0] rd;
  logic        err;
  int          checks;
  int          miscompares;

  amsr_link_if lnk ();
  amsr_converter u_amsr_converter (.pclk(pclk), .presetn(presetn), .link(lnk),
    .master_mode(master_mode), .clock_edge_invert_sel(clock_edge_invert_sel),
    .sync_active_high(sync_active_high), .sample_data(sample_data), .sample_hold(sample_hold),
    .conv_busy(conv_busy));
  amsr_host u_amsr_host (.pclk(pclk), .presetn(presetn), .link(lnk), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_event(rx_event));
  amsr_link_properties u_amsr_link_properties (.pclk(pclk), .presetn(presetn),
    .conversion_start_n(lnk.conversion_start_n), .bit_clock_oe(lnk.bit_clock_oe),
    .bit_clock(lnk.bit_clock), .frame_sync(lnk.frame_sync),
    .serial_result_out(lnk.serial_result_out));

  always #10 pclk = ~pclk;
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  // config pins only change under reset, so idle clock level never jumps
  task automatic do_reset(input logic m, input logic inv);
    presetn <= 1'b0;
    master_mode <= m;
    clock_edge_invert_sel <= inv;
    lnk.ext_bit_clock <= inv;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask : do_reset

  // only the watchdog ends a wait for pready; one idle edge keeps psel from
  // being assigned twice in one time step on back-to-back calls
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // bounded wait: start pulse when sel is 0, kept word when sel is 1
  task automatic wait_for(input logic sel, output int n);
    n = 0;
    while (!(sel ? rx_event === 1'b1 : lnk.conversion_start_n === 1'b0) && n < 1000)
    begin
      @(posedge pclk);
      n++;
    end
    check("wait bound", 32'(n < 1000), 32'h1);
  endtask : wait_for
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    do_reset(1'b1, 1'b0);
    check("oe master", 32'(lnk.bit_clock_oe), 32'h1);
    apb(1'b0, ADDR_CTRL, 32'h0);
    check("ctrl reset", rd, 32'(CTRL_RST));
    apb(1'b0, ADDR_PERIOD, 32'h0);
    check("period reset", rd, 32'(PERIOD_RST));
    apb(1'b0, 8'h3C, 32'h0);
    check("unmapped err", 32'(err), 32'h1);
    check("unmapped data", rd, 32'h0);
    apb(1'b1, ADDR_TXDATA, 32'h0000B00C);
    apb(1'b0, ADDR_TXDATA, 32'h0);
    check("txdata", rd, 32'h0000B00C);
    apb(1'b1, ADDR_CTRL, 32'h8);
    check("dir oe", 32'(lnk.port_data_oe), 32'h2);
    apb(1'b1, ADDR_CTRL, 32'h0);
    check("dir off", 32'(lnk.port_data_oe), 32'h0);
    $display("test regs done");
  endtask : t_regs

  task automatic t_stream();
    int n;
    sample_data <= 16'hA5C3;
    apb(1'b1, ADDR_CTRL, 32'h3);
    wait_for(1'b0, n);
    repeat (5) @(posedge pclk);
    check("hold", 32'(sample_hold), 32'h1);
    check("busy", 32'(conv_busy), 32'h1);
    wait_for(1'b1, n);
    check("two discarded", 32'(n > 250), 32'h1);
    @(posedge pclk);
    check("event pulse", 32'(rx_event), 32'h0);
    sample_data <= 16'h0001;
    apb(1'b0, ADDR_DATA, 32'h0);
    check("first word", rd, 32'h0000A5C3);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check("status", rd & 32'h5, 32'h5);
    apb(1'b1, ADDR_STATUS, 32'h1);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check("valid clear", rd & 32'h1, 32'h0);
    wait_for(1'b1, n);
    check("word gap", 32'(n < 110), 32'h1);
    apb(1'b0, ADDR_DATA, 32'h0);
    check("second word", rd, 32'h00000001);
    apb(1'b0, ADDR_COUNT, 32'h0);
    check("count", rd, 32'h2);
    $display("test stream done");
  endtask : t_stream

  // slave clock idles high with inverted edges; data shifts on rising
  task automatic t_slave();
    int n;
    sync_active_high <= 1'b1;
    do_reset(1'b0, 1'b1);
    check("oe slave", 32'(lnk.bit_clock_oe), 32'h0);
    check("frame idle high pol", 32'(lnk.frame_sync), 32'h0);
    sample_data <= 16'h6E19;
    apb(1'b1, ADDR_PERIOD, 32'h0000012C);
    apb(1'b1, ADDR_CTRL, 32'h3);
    wait_for(1'b0, n);
    repeat (45) @(posedge pclk);
    for (int i = 0; i < 16; i++)
    begin
      lnk.ext_bit_clock <= 1'b0;
      repeat (4) @(posedge pclk);
      check("slave bit", 32'(lnk.serial_result_out), 32'(sample_data[15 - i]));
      check("slave frame", 32'(lnk.frame_sync), 32'(i == 0));
      lnk.ext_bit_clock <= 1'b1;
      repeat (4) @(posedge pclk);
    end
    apb(1'b1, ADDR_CTRL, 32'h0);
    $display("test slave done");
  endtask : t_slave
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    master_mode = 1'b1;
    clock_edge_invert_sel = 1'b0;
    sync_active_high = 1'b0;
    sample_data = 16'h0000;
    paddr = 8'h00;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0;
    lnk.ext_bit_clock = 1'b0;
    checks = 0;
    miscompares = 0;
    t_regs();
    t_stream();
    t_slave();
    conclude();
  end

  // whole run needs well under 2000 cycles
  initial
  begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    conclude();
  end
endmodule : adc_master_serial_readout_tb_top
